//--- design/glue_logic.sv
// two three-input look-up tables with a shared sequential element
// assumes an axi4-lite master on aclk; pins, events and peripherals are async
//
// Design decisions made here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module glue_logic
  import glue_pkg::*;
(
  // clock, reset, freeze
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // axi4-lite write channels
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // asynchronous sources, pins as {table1 in2..in0, table0 in2..in0}
  input wire logic [5:0] table_input_pin,
  input wire logic event_line_zero,
  input wire logic event_line_one,
  input wire logic [NUM_PERIPH-1:0] periph_in,
  // outputs
  output logic [NUM_TABLES-1:0] table_output_event,
  output logic [NUM_TABLES-1:0] table_out_pin,
  output logic [NUM_TABLES-1:0] pin_out_override,
  output logic sequential_element_output
);

  localparam int ASYNC_W = 6 + 2 + NUM_PERIPH;

  // register storage
  logic [7:0] global_control;
  seq_mode_e seq_function_select;
  table_control_a_s table_control_a [NUM_TABLES];
  logic [7:0] table_control_b [NUM_TABLES];
  logic [3:0] table_control_c [NUM_TABLES];
  logic [7:0] lookup_pattern [NUM_TABLES];

  // datapath
  logic [ASYNC_W-1:0] async_meta;
  logic [ASYNC_W-1:0] async_sync;
  logic [5:0] pin_s;
  logic [1:0] event_s;
  logic [NUM_PERIPH-1:0] periph_s;
  logic [NUM_TABLES-1:0] table_on;
  logic [NUM_TABLES-1:0] table_raw;
  logic [NUM_TABLES-1:0] tick;
  logic [NUM_TABLES-1:0] in2_prev;
  logic [NUM_TABLES-1:0] stage_out;
  logic [NUM_TABLES:0] link_chain;
  logic seq_q;

  // bus
  logic wr_go;
  logic [IDX_W-1:0] wr_idx;
  logic [7:0] wr_byte;
  logic [IDX_W-1:0] rd_idx;
  logic [7:0] next_rdata;

  // index of one register of a table group
  function automatic logic [IDX_W-1:0] table_idx(input int n, input logic [1:0] off);
    table_idx = IDX_TABLE_BASE + IDX_W'(n * IDX_TABLE_STEP) + IDX_W'(off);
  endfunction

  // true for every index that holds a register
  function automatic logic mapped(input logic [IDX_W-1:0] idx);
    mapped = (idx <= IDX_SEQ) || (idx == IDX_STATUS) ||
             (idx >= IDX_TABLE_BASE && idx < table_idx(NUM_TABLES, OFF_CTRL_A));
  endfunction

  // source multiplexer shared by all six inputs
  function automatic logic pick_source(
    input logic [3:0] code,
    input logic pin,
    input logic link,
    input logic fb,
    input logic [1:0] ev,
    input logic [NUM_PERIPH-1:0] per
  );
    case (code)
      SRC_MASK: pick_source = 1'b0;
      SRC_FEEDBACK: pick_source = fb;
      SRC_LINK: pick_source = link;
      SRC_EVENT_LINE_ZERO: pick_source = ev[0];
      SRC_EVENT_LINE_ONE: pick_source = ev[1];
      SRC_PIN: pick_source = pin;
      default: begin
        if (code >= SRC_PERIPH_BASE && code < SRC_PERIPH_BASE + 4'(NUM_PERIPH)) begin
          pick_source = per[2'(code - SRC_PERIPH_BASE)];
        end else begin
          pick_source = 1'b0;
        end
      end
    endcase
  endfunction

  // two-flop synchroniser for everything from outside aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      async_meta <= '0;
      async_sync <= '0;
    end else if (ce) begin
      async_meta <= {periph_in, event_line_one, event_line_zero, table_input_pin};
      async_sync <= async_meta;
    end
  end

  assign pin_s = async_sync[5:0];
  assign event_s = async_sync[7:6];
  assign periph_s = async_sync[ASYNC_W-1:8];

  // the highest table has no higher neighbour to link from
  assign link_chain[NUM_TABLES] = 1'b0;

  // bus handshake: address and data are taken together, one at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !wr_go && !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !wr_go && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_go = s_axi_awready && s_axi_wready;
  assign wr_idx = s_axi_awaddr[ADDR_W-1:2];
  // only lane 0 carries register data
  assign wr_byte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;

  // read channel; data are sampled when the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, next_rdata};
        s_axi_rresp <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign rd_idx = s_axi_araddr[ADDR_W-1:2];

  // read mux; unmapped and reserved bits read zero
  always_comb begin
    next_rdata = 8'h00;
    if (rd_idx == IDX_GLOBAL) begin
      next_rdata = global_control;
    end
    if (rd_idx == IDX_SEQ) begin
      next_rdata = {4'h0, seq_function_select};
    end
    if (rd_idx == IDX_STATUS) begin
      next_rdata = {5'h00, seq_q, stage_out};
    end
    for (int n = 0; n < NUM_TABLES; n++) begin
      if (rd_idx == table_idx(n, OFF_CTRL_A)) begin
        next_rdata = table_control_a[n];
      end
      if (rd_idx == table_idx(n, OFF_CTRL_B)) begin
        next_rdata = table_control_b[n];
      end
      if (rd_idx == table_idx(n, OFF_CTRL_C)) begin
        next_rdata = {4'h0, table_control_c[n]};
      end
      if (rd_idx == table_idx(n, OFF_PATTERN)) begin
        next_rdata = lookup_pattern[n];
      end
    end
  end

  // global enable; standby bit is kept only for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_control <= RESET_BYTE;
    end else if (ce && wr_go && s_axi_wstrb[0] && wr_idx == IDX_GLOBAL) begin
      global_control <= wr_byte & GLOBAL_WMASK;
    end
  end

  // sequential select, locked while the even table runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_function_select <= seq_off;
    end else if (ce && wr_go && s_axi_wstrb[0] && wr_idx == IDX_SEQ) begin
      if (!table_control_a[0].enable) begin
        seq_function_select <= seq_mode_e'(wr_byte[3:0]);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TABLES; g++) begin : gen_table
      logic in0;
      logic in1;
      logic in2;
      logic wr_lane;
      stage_cfg_s cfg;

      assign wr_lane = ce && wr_go && s_axi_wstrb[0];

      // control a: whole byte while stopped, else enable only
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          table_control_a[g] <= table_control_a_s'(RESET_BYTE);
        end else if (wr_lane && wr_idx == table_idx(g, OFF_CTRL_A)) begin
          if (!table_control_a[g].enable) begin
            table_control_a[g] <= table_control_a_s'(wr_byte & CTRL_A_WMASK);
          end else begin
            table_control_a[g].enable <= wr_byte[0];
          end
        end
      end

      // control b and c: writable only while the table is stopped
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          table_control_b[g] <= RESET_BYTE;
          table_control_c[g] <= RESET_NIBBLE;
        end else if (wr_lane && !table_control_a[g].enable) begin
          if (wr_idx == table_idx(g, OFF_CTRL_B)) begin
            table_control_b[g] <= wr_byte;
          end
          if (wr_idx == table_idx(g, OFF_CTRL_C)) begin
            table_control_c[g] <= wr_byte[3:0];
          end
        end
      end

      // pattern is not locked by the enable
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          lookup_pattern[g] <= RESET_BYTE;
        end else if (wr_lane && wr_idx == table_idx(g, OFF_PATTERN)) begin
          lookup_pattern[g] <= wr_byte;
        end
      end

      assign table_on[g] = global_control[GLOBAL_ENABLE_BIT] && table_control_a[g].enable;

      // input selection
      assign in0 = pick_source(table_control_b[g][INPUT0_SOURCE_SELECT_LSB +: 4], pin_s[3*g],
                               link_chain[g+1], seq_q, event_s, periph_s);
      assign in1 = pick_source(table_control_b[g][INPUT1_SOURCE_SELECT_LSB +: 4], pin_s[3*g+1],
                               link_chain[g+1], seq_q, event_s, periph_s);
      assign in2 = pick_source(table_control_c[g][INPUT2_SOURCE_SELECT_LSB +: 4], pin_s[3*g+2],
                               link_chain[g+1], seq_q, event_s, periph_s);

      // look-up; a stopped table drives low
      assign table_raw[g] = table_on[g] && lookup_pattern[g][{in2, in1, in0}];
      assign link_chain[g] = table_raw[g];

      // input 2 as clock becomes a tick on its rising edge
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          in2_prev[g] <= 1'b0;
        end else if (ce) begin
          in2_prev[g] <= in2;
        end
      end

      assign tick[g] = table_control_a[g].table_clock_select ? (in2 && !in2_prev[g]) : 1'b1;

      assign cfg.enable = table_on[g];
      assign cfg.tick = tick[g];
      assign cfg.filter = table_control_a[g].output_filter_select;
      assign cfg.edge_on = table_control_a[g].edge_detect_on;

      lut_output_stage u_stage (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .cfg(cfg),
        .raw(table_raw[g]),
        .stage_out(stage_out[g])
      );
    end
  endgenerate

  // sequential element, flip-flop modes on the even table's clock, latch modes level sensitive; a freeze on ce stops it too
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_q <= 1'b0;
    end else if (ce) begin
      if (!table_on[0]) begin
        seq_q <= 1'b0;
      end else begin
        unique case (seq_function_select)
          d_flipflop_mode: begin
            if (tick[0] && stage_out[1]) begin
              seq_q <= stage_out[0];
            end
          end
          jk_flipflop_mode: begin
            if (tick[0]) begin
              case ({stage_out[0], stage_out[1]})
                2'b01: seq_q <= 1'b0;
                2'b10: seq_q <= 1'b1;
                2'b11: seq_q <= !seq_q;
                default: seq_q <= seq_q;
              endcase
            end
          end
          d_latch_mode: begin
            if (stage_out[1]) begin
              seq_q <= stage_out[0]; // level sensitive, so no tick
            end
          end
          set_reset_latch_mode: begin
            // both high is forbidden; the latch then holds
            if (stage_out[0] && !stage_out[1]) begin
              seq_q <= 1'b1;
            end else if (stage_out[1] && !stage_out[0]) begin
              seq_q <= 1'b0;
            end
          end
          seq_off: seq_q <= 1'b0;
          default: seq_q <= 1'b0;
        endcase
      end
    end
  end

  // registered outputs to pins and the event network
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      table_output_event <= '0;
      table_out_pin <= '0;
      pin_out_override <= '0;
      sequential_element_output <= 1'b0;
    end else if (ce) begin
      table_output_event <= stage_out;
      sequential_element_output <= seq_q;
      for (int n = 0; n < NUM_TABLES; n++) begin
        pin_out_override[n] <= table_on[n] && table_control_a[n].pin_output_enable;
        table_out_pin[n] <= stage_out[n] && table_control_a[n].pin_output_enable;
      end
    end
  end

endmodule

//--- design/lut_output_stage.sv
// synchroniser, filter and rising-edge detector behind one table
// assumes the parent supplies a one-cycle tick per selected table clock
`timescale 1ns/1ps
module lut_output_stage
  import glue_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // configuration and data
  input wire stage_cfg_s cfg,
  input wire logic raw,
  output logic stage_out
);

  logic sync_a;
  logic sync_b;
  logic filt_a;
  logic filt_q;
  logic prev;
  logic filtered;

  // filter chain; a disabled table is wiped at the next edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      filt_a <= 1'b0;
      filt_q <= 1'b0;
    end else if (ce) begin
      if (!cfg.enable) begin
        sync_a <= 1'b0;
        sync_b <= 1'b0;
        filt_a <= 1'b0;
        filt_q <= 1'b0;
      end else if (cfg.tick) begin
        sync_a <= raw;
        sync_b <= sync_a;
        filt_a <= sync_b;
        if (filt_a == sync_b) begin
          filt_q <= filt_a; // two agreeing samples suppress spikes
        end
      end
    end
  end

  // reserved code falls back to the plain table output
  always_comb begin
    unique case (cfg.filter)
      synchronizer_only: filtered = sync_b;
      filter_full: filtered = filt_q;
      filter_none: filtered = raw;
      filter_reserved: filtered = raw;
    endcase
  end

  // edge detector history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev <= 1'b0;
    end else if (ce) begin
      if (!cfg.enable) begin
        prev <= 1'b0;
      end else if (cfg.tick) begin
        prev <= filtered;
      end
    end
  end

  // pulse lasts one period of the selected table clock
  assign stage_out = cfg.edge_on ? (filtered & ~prev) : filtered;

endmodule

//--- inc/glue_pkg.sv
// constants, types and register map of the two-table glue logic block
// assumes a 32-bit axi4-lite register bus with word-aligned registers
package glue_pkg;

  localparam int NUM_TABLES = 2;
  localparam int IDX_W = 5;
  localparam int ADDR_W = 7;

  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_GLOBAL = 5'h00;
  localparam logic [IDX_W-1:0] IDX_SEQ = 5'h01;
  localparam logic [IDX_W-1:0] IDX_TABLE_BASE = 5'h05;
  localparam logic [IDX_W-1:0] IDX_TABLE_STEP = 5'h04;
  localparam logic [IDX_W-1:0] IDX_STATUS = 5'h10;

  // offsets inside one table group
  localparam logic [1:0] OFF_CTRL_A = 2'h0;
  localparam logic [1:0] OFF_CTRL_B = 2'h1;
  localparam logic [1:0] OFF_CTRL_C = 2'h2;
  localparam logic [1:0] OFF_PATTERN = 2'h3;

  // field positions
  localparam int GLOBAL_ENABLE_BIT = 0;
  localparam int RUN_STANDBY_BIT = 6;
  localparam int INPUT0_SOURCE_SELECT_LSB = 0;
  localparam int INPUT1_SOURCE_SELECT_LSB = 4;
  localparam int INPUT2_SOURCE_SELECT_LSB = 0;
  localparam int STATUS_SEQ_BIT = 2;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] RESET_NIBBLE = 4'h0;

  // bits of the global and control a registers that software may set
  localparam logic [7:0] GLOBAL_WMASK = 8'h41;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf9;

  // input source codes
  localparam logic [3:0] SRC_MASK = 4'h0;
  localparam logic [3:0] SRC_FEEDBACK = 4'h1;
  localparam logic [3:0] SRC_LINK = 4'h2;
  localparam logic [3:0] SRC_EVENT_LINE_ZERO = 4'h3;
  localparam logic [3:0] SRC_EVENT_LINE_ONE = 4'h4;
  localparam logic [3:0] SRC_PIN = 4'h5;
  localparam logic [3:0] SRC_PERIPH_BASE = 4'h6;
  localparam int NUM_PERIPH = 4;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    seq_off = 4'h0,
    d_flipflop_mode = 4'h1,
    jk_flipflop_mode = 4'h2,
    d_latch_mode = 4'h3,
    set_reset_latch_mode = 4'h4
  } seq_mode_e;

  typedef enum logic [1:0] {
    filter_none = 2'h0,
    synchronizer_only = 2'h1,
    filter_full = 2'h2,
    filter_reserved = 2'h3
  } filter_mode_e;

  typedef struct packed {
    logic edge_detect_on;
    logic table_clock_select;
    filter_mode_e output_filter_select;
    logic pin_output_enable;
    logic [1:0] unused;
    logic enable;
  } table_control_a_s;

  // what the output stage of one table needs each cycle
  typedef struct packed {
    logic enable;
    logic tick;
    filter_mode_e filter;
    logic edge_on;
  } stage_cfg_s;

endpackage

//--- tb/glue_far_side.sv
// far side model: pins, event lines and peripheral signals
// assumes the bench changes want and slow just after a rising edge
`timescale 1ns/1ps
module glue_far_side
  import glue_pkg::*;
(
  // control from the bench
  input wire logic aclk,
  input wire logic [11:0] want,
  input wire logic slow,
  // lines into the block
  output logic [5:0] table_input_pin,
  output logic event_line_zero,
  output logic event_line_one,
  output logic [NUM_PERIPH-1:0] periph_in
);
  logic [11:0] d0 = 12'h000;
  logic [11:0] d1 = 12'h000;
  // lines are async: they move off the clock edge, slow adds a cycle
  always @(posedge aclk) begin
    d1 <= d0;
    d0 <= want;
  end
  assign #3 {periph_in, event_line_one, event_line_zero, table_input_pin} = slow ? d1 : d0;
endmodule

//--- tb/glue_logic_properties.sv
// port checker for the two-table glue logic block
// assumes it is bound into glue_logic and ce stays high during bus traffic
`timescale 1ns/1ps
module glue_logic_properties
  import glue_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // block outputs
  input wire logic [NUM_TABLES-1:0] table_output_event,
  input wire logic [NUM_TABLES-1:0] table_out_pin,
  input wire logic sequential_element_output
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic wr;
  logic [4:0] idx;
  // an accepted write of the low byte
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  assign idx = s_axi_awaddr[6:2];
  a_ready_pair: assert property (s_axi_awready == s_axi_wready) else $error("write readies split");
  a_one_write: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("write taken during response");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid) else $error("late write response");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read data");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_pin_gated: assert property ((table_out_pin & ~table_output_event) == 2'h0) else $error("pin without output");
  a_off_clears0: assert property (wr && idx == 5'h05 && !s_axi_wdata[0] |-> ##[1:8] !table_output_event[0])
    else $error("table 0 output kept");
  a_off_clears1: assert property (wr && idx == 5'h09 && !s_axi_wdata[0] |-> ##[1:8] !table_output_event[1])
    else $error("table 1 output kept");
  a_seq_cleared: assert property (wr && idx == 5'h05 && !s_axi_wdata[0] |-> ##[1:4] !sequential_element_output)
    else $error("sequential output kept");
  a_global_off: assert property (wr && idx == 5'h00 && !s_axi_wdata[0] |-> ##[1:8] table_output_event == 2'h0)
    else $error("outputs kept after global off");
  // main scenarios reached
  cover property ($rose(sequential_element_output));
  cover property (wr && idx == 5'h01);
  cover property ($rose(table_out_pin[0]));
endmodule

bind glue_logic glue_logic_properties chk (.*);

//--- tb/glue_logic_test.sv
// self-checking bench for the glue logic block
// assumes the far side model and the port checker bound to the design
`timescale 1ns/1ps
module glue_logic_test;
  import glue_pkg::*;
  logic aclk = 0, aresetn = 0, ce = 1, slow = 0;
  logic [6:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [5:0] table_input_pin;
  logic event_line_zero, event_line_one, sequential_element_output;
  logic [NUM_PERIPH-1:0] periph_in;
  logic [NUM_TABLES-1:0] table_output_event, table_out_pin, pin_out_override;
  logic [11:0] want = 0;
  logic [33:0] exp_q[$];
  int n_fail = 0, total_checks = 0;

  glue_logic uut (.*);
  glue_far_side fs (.*);

  always #5 aclk = ~aclk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic guard(input int k);
    if (k >= 50) begin
      n_fail++;
      close_out();
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // bus write: address and data offered together, each released when taken
  task automatic wr(input logic [4:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int k;
    @(posedge aclk);
    exp_q.push_back({r, 32'h0});
    s_axi_awaddr <= {i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      k++;
    end while (!s_axi_bvalid && k < 50);
    s_axi_bready <= 0;
    guard(k);
  endtask

  task automatic rd(input logic [4:0] i, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    int k;
    @(posedge aclk);
    exp_q.push_back({r, 24'h0, d});
    s_axi_araddr <= {i, 2'h0};
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    k = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      k++;
    end while (!s_axi_rvalid && k < 50);
    s_axi_rready <= 0;
    guard(k);
  endtask

  // responses are matched against the oldest note
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) cmp({s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  end

  initial begin
    logic [7:0] pat;
    logic [11:0] v;
    logic q, g, d, x;
    int c, k, base;
    void'($urandom(58));
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(5'h05, 8'h00);
    rd(5'h02, 8'h00, RESP_SLVERR);
    wr(5'h03, 8'hff, RESP_SLVERR);
    wr(IDX_GLOBAL, 8'h01);
    // truth table over all pin combinations, prompt and slow far side
    pat = 8'($urandom);
    wr(5'h06, 8'h55);
    wr(5'h07, 8'h05);
    wr(5'h08, pat);
    wr(5'h05, 8'h01);
    for (c = 0; c < 8; c++) begin
      want <= 12'(c);
      slow <= c[0];
      tick(12);
      rd(IDX_STATUS, {7'h0, pat[c]});
    end
    // locked fields while running
    wr(5'h06, 8'h00);
    rd(5'h06, 8'h55);
    wr(5'h05, 8'h08);
    rd(5'h05, 8'h00);
    wr(5'h05, 8'h09);
    rd(5'h05, 8'h09);
    wr(IDX_SEQ, 8'h02);
    rd(IDX_SEQ, 8'h00);
    // every source code on input 0; table 1 passes its pin 0
    wr(5'h0a, 8'h05);
    wr(5'h0c, 8'haa);
    wr(5'h09, 8'h01);
    for (c = 0; c < 16; c++) begin
      wr(5'h05, 8'h00);
      wr(5'h06, 8'(c));
      wr(5'h07, 8'h00);
      wr(5'h08, 8'haa);
      wr(5'h05, 8'h01);
      v = 12'($urandom);
      want <= v;
      tick(12);
      x = (c < 2 || c > 9) ? 1'b0 : c == 2 ? v[3] : c == 5 ? v[0] : c < 5 ? v[c+3] : v[c+2];
      rd(IDX_STATUS, {5'h0, 1'b0, v[3], x});
    end
    // sequential modes, reserved code last; inputs parked low so enable sees no stale d or gate
    for (c = 1; c < 6; c++) begin
      want <= 12'h000;
      wr(5'h05, 8'h00);
      wr(IDX_SEQ, 8'(c));
      wr(5'h06, 8'h05);
      wr(5'h05, 8'h01);
      q = 0;
      repeat (8) begin
        {d, g} = 2'($urandom);
        if ((c == 2 || c == 4) && d) g = 0;
        if (c == 1 || c == 3) q = g ? d : q;
        else if (c != 5) q = d ? 1'b1 : g ? 1'b0 : q;
        want <= {8'h0, g, 2'h0, d};
        tick(12);
        rd(IDX_STATUS, {5'h0, q, g, d});
      end
    end
    // output delay for each filter code, then edge pulse
    for (c = 0; c < 5; c++) begin
      wr(5'h05, 8'h00);
      wr(5'h05, c == 4 ? 8'h99 : {2'h0, 2'(c), 4'h9});
      want <= 0;
      tick(12);
      want <= 12'h1;
      k = 0;
      do begin
        @(posedge aclk);
        k++;
      end while (!table_output_event[0] && k < 50);
      guard(k);
      if (c == 0) base = k;
      cmp(34'(k - base), (c == 2) ? 34'h4 : (c == 1 || c == 4) ? 34'h2 : 34'h0);
      cmp({30'h0, table_out_pin, pin_out_override}, 34'h5);
    end
    @(posedge aclk);
    cmp({33'h0, table_output_event[0]}, 34'h0);
    // freeze: outputs hold while ce is low, then catch up
    want <= 12'h008;
    ce <= 0;
    tick(8);
    cmp({32'h0, table_output_event}, 34'h0);
    ce <= 1;
    tick(8);
    cmp({32'h0, table_output_event}, 34'h2);
    // table 1 clocked by its input 2: the synchroniser moves only on rising edges of pin 5
    wr(5'h09, 8'h00);
    wr(5'h0b, 8'h05);
    wr(5'h09, 8'h51);
    for (c = 0; c < 3; c++) begin
      want <= c[0] ? 12'h008 : 12'h028;
      tick(12);
      rd(IDX_STATUS, (c == 2) ? 8'h02 : 8'h00);
    end
    wr(5'h09, 8'h00);
    wr(IDX_GLOBAL, 8'h00);
    tick(12);
    rd(IDX_STATUS, 8'h00);
    close_out();
  end
endmodule
